/* pkg/sbd_cfg.svh */
// Functional notes
// - Nine BCD digits out, 1 kHz first
// - After preset returned digits read 3 GHz
// - Preset held whole cycle forces 3 GHz
// - Nine further steps follow digit steps
// - Divider divides frequency by band number, band 0 by one
// - Non-zero remainder raises remainder indication
// - Exact quotient transferred to tuning register
// - Data lines: input when low, own when high
// - Divider inputs carry weights 8,4,2,1
// - 15999.999 MHz by three leaves no remainder
// - Tuning register drives M and N fields
// - Data cycle lasts eighteen steps
`ifndef SBD_CFG_SVH
`define SBD_CFG_SVH
`define SBD_DIGITS 9
`define SBD_STEPS 18
`define SBD_LAST_STEP 5'h11
`define SBD_DIV_FIRST 5'h09
`define SBD_PRESET_FREQ 36'h003000000
`define SBD_KHZ_PER_10MHZ 34'h0000002710
`define SBD_TUNE_SCALE 12'h003
`define SBD_TUNE_OFFSET 12'h32B
`define SBD_FIFO_DEPTH 16
`endif

/* pkg/sbd_pkg.sv */
`include "sbd_cfg.svh"
package sbd_pkg;
  typedef logic [3:0] sbd_digit_t;
  typedef logic [35:0] sbd_freq_t;
  typedef struct packed {
    logic [4:0] step;
    logic sync1;
    logic sync2;
    logic preset_ok;
    logic carry;
    logic dir_up;
    sbd_freq_t freq;
    sbd_freq_t div;
    logic [3:0] rem;
    logic flag_n;
    sbd_digit_t fout;
    sbd_digit_t fret;
    logic pend;
    sbd_freq_t pend_q;
    logic [4:0] m;
    logic [5:0] n;
  } sbd_state_s;
endpackage

/* rtl/sbd_divider_chain.sv */
`timescale 1ns/1ns
`include "sbd_cfg.svh"
module sbd_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sbd_fifo_s;
  sbd_fifo_s st;
  sbd_fifo_s next_st;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data = st.mem[st.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module sbd_divider_chain #(
  parameter int FIFO_DEPTH = `SBD_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Front panel preset key, asynchronous
  input wire logic preset_req,
  // Controller adjust requests and band
  input wire logic adj_up,
  input wire logic adj_down,
  input wire logic [3:0] band_number,
  // Step position
  output logic [4:0] step_index,
  output logic shift_phase,
  // Frequency register serial digit out
  output logic freq_out_weight8,
  output logic freq_out_weight4,
  output logic freq_out_weight2,
  output logic freq_out_weight1,
  output sbd_pkg::sbd_digit_t freq_return_digit,
  // Divider serial inputs and data path
  output logic divider_in_weight8,
  output logic divider_in_weight4,
  output logic divider_in_weight2,
  output logic divider_in_weight1,
  output logic [3:0] data_path,
  // Remainder to controller
  output logic remainder_flag_n,
  // Loop tuning words
  output logic tune_valid,
  input wire logic tune_take,
  output logic [4:0] loop_tune_m_field,
  output logic [5:0] loop_tune_n_field
);
  import sbd_pkg::*;
  sbd_state_s st;
  sbd_state_s next_st;
  logic fifo_in_ready;
  logic fifo_out_valid;
  sbd_freq_t fifo_out_data;
  logic stall;
  sbd_digit_t dig;
  sbd_digit_t ret;
  logic ret_carry;
  logic [7:0] part;
  logic [3:0] divisor;
  sbd_digit_t qdig;
  logic [3:0] new_rem;
  logic [10:0] tune_word;
  logic add_cin;
  logic add_up;

  // BCD quotient times band, scaled to 11 tuning bits
  function automatic logic [10:0] sbd_tune(input sbd_freq_t q, input logic [3:0] b);
    logic [33:0] acc;
    logic [33:0] f10;
    logic [11:0] x;
    acc = '0;
    f10 = '0;
    x = '0;
    for (int i = `SBD_DIGITS - 1; i >= 0; i--) begin
      acc = 34'(acc * 34'hA) + 34'(q[i*4 +: 4]);
    end
    f10 = 34'(acc * 34'(b)) / `SBD_KHZ_PER_10MHZ;
    x = 12'(f10 * 34'(`SBD_TUNE_SCALE)) - `SBD_TUNE_OFFSET;
    return x[10:0];
  endfunction

  sbd_fifo #(.WIDTH(36), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(st.pend),
    .in_ready(fifo_in_ready),
    .in_data(st.pend_q),
    .out_valid(fifo_out_valid),
    .out_ready(tune_take),
    .out_data(fifo_out_data)
  );

  // Port views of the state
  assign step_index = st.step;
  assign shift_phase = (st.step >= `SBD_DIV_FIRST);
  assign {freq_out_weight8, freq_out_weight4, freq_out_weight2, freq_out_weight1} = st.fout;
  assign {divider_in_weight8, divider_in_weight4, divider_in_weight2, divider_in_weight1} =
    st.fout;
  assign data_path = shift_phase ? st.div[35:32] : st.fout;
  assign freq_return_digit = st.fret;
  assign remainder_flag_n = st.flag_n;
  assign tune_valid = fifo_out_valid;
  assign loop_tune_m_field = st.m;
  assign loop_tune_n_field = st.n;
  assign divisor = (band_number == 4'h0) ? 4'h1 : band_number;
  assign stall = (st.step == `SBD_LAST_STEP) && st.pend && !fifo_in_ready;
  assign tune_word = sbd_tune(fifo_out_data, band_number);

  // Plus-minus-one adder; the step 0 digit takes the adjust request directly
  always_comb begin
    dig = st.freq[3:0];
    add_cin = (st.step == 5'h00) ? (adj_up || adj_down) : st.carry;
    add_up = (st.step == 5'h00) ? adj_up : st.dir_up;
    ret = dig;
    ret_carry = 1'b0;
    if (add_cin && add_up) begin
      ret = (dig == 4'h9) ? 4'h0 : dig + 4'h1;
      ret_carry = (dig == 4'h9);
    end else if (add_cin) begin
      ret = (dig == 4'h0) ? 4'h9 : dig - 4'h1;
      ret_carry = (dig == 4'h0);
    end
  end

  // One long-division step, most significant digit first
  always_comb begin
    part = 8'((st.step == `SBD_DIV_FIRST) ? 8'h00 : 8'(st.rem) * 8'h0A) + 8'(st.div[35:32]);
    qdig = 4'(part / 8'(divisor));
    new_rem = 4'(part % 8'(divisor));
  end

  // Step sequencer, registers 1 to 3
  always_comb begin
    next_st = st;
    next_st.sync1 = preset_req;
    next_st.sync2 = st.sync1;
    if (!stall) begin
      next_st.step = (st.step == `SBD_LAST_STEP) ? 5'h00 : st.step + 5'h01;
    end
    if (st.step == 5'h00) begin
      next_st.dir_up = adj_up;
      next_st.preset_ok = st.sync2;
    end else begin
      next_st.preset_ok = st.preset_ok && st.sync2;
    end
    if (st.step < `SBD_DIV_FIRST) begin
      next_st.freq = {ret, st.freq[35:4]};
      next_st.carry = ret_carry;
      next_st.fret = ret;
      next_st.div = {st.fout, st.div[35:4]};
    end else if (!stall) begin
      next_st.div = {st.div[31:0], qdig};
      next_st.rem = new_rem;
    end
    if (st.step == `SBD_LAST_STEP && !stall) begin
      next_st.flag_n = (new_rem == 4'h0);
      if (new_rem == 4'h0) begin
        next_st.pend = 1'b1;
        next_st.pend_q = {st.div[31:0], qdig};
      end
      if (st.preset_ok && st.sync2) begin
        next_st.freq = `SBD_PRESET_FREQ;
      end
    end
    if (st.pend && fifo_in_ready && !(st.step == `SBD_LAST_STEP && new_rem == 4'h0)) begin
      next_st.pend = 1'b0;
    end
    next_st.fout = (next_st.step < `SBD_DIV_FIRST) ? next_st.freq[3:0] : 4'h0;
    if (fifo_out_valid && tune_take) begin
      {next_st.n, next_st.m} = tune_word;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.freq <= `SBD_PRESET_FREQ;
      st.flag_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* verification/sbd_divider_chain_chk.sv */
`timescale 1ns/1ns
module sbd_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Step and digit ports
  input wire logic [4:0] step_index,
  input wire logic shift_phase,
  input wire logic freq_out_weight8,
  input wire logic freq_out_weight4,
  input wire logic freq_out_weight2,
  input wire logic freq_out_weight1,
  input wire logic divider_in_weight8,
  input wire logic divider_in_weight4,
  input wire logic divider_in_weight2,
  input wire logic divider_in_weight1,
  input wire logic [3:0] data_path,
  // Remainder and tuning
  input wire logic remainder_flag_n,
  input wire logic tune_valid,
  input wire logic tune_take
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Packed digit views
  wire [3:0] fo = {freq_out_weight8, freq_out_weight4, freq_out_weight2, freq_out_weight1};
  wire [3:0] di = {divider_in_weight8, divider_in_weight4, divider_in_weight2, divider_in_weight1};
  a_step_advance: assert property (step_index < 5'h11 |=> step_index == $past(step_index) + 5'h01) else $error("step skipped");
  a_cycle_wrap: assert property (step_index == 5'h11 |=> step_index inside {5'h00, 5'h11}) else $error("bad wrap");
  a_phase_map: assert property (shift_phase == (step_index >= 5'h09)) else $error("phase wrong");
  a_idle_zero: assert property (shift_phase |-> fo == 4'h0) else $error("digit in idle");
  a_div_copy: assert property (di == fo) else $error("divider input differs");
  a_path_sel: assert property (!shift_phase |-> data_path == fo) else $error("path wrong");
  a_bcd_digit: assert property (fo <= 4'h9) else $error("not bcd");
  a_flag_hold: assert property (step_index != 5'h00 |-> $stable(remainder_flag_n)) else $error("flag moved");
  a_tune_exact: assert property ($rose(tune_valid) |-> remainder_flag_n) else $error("push on remainder");
  // Main scenarios
  c_remainder: cover property (!remainder_flag_n);
  c_tune_pop: cover property (tune_valid && tune_take);
  c_shift: cover property ($rose(shift_phase));
endmodule
bind sbd_divider_chain sbd_chk chk_u (.sys_clk, .rst_n, .step_index, .shift_phase,
  .freq_out_weight8, .freq_out_weight4, .freq_out_weight2, .freq_out_weight1,
  .divider_in_weight8, .divider_in_weight4, .divider_in_weight2, .divider_in_weight1,
  .data_path, .remainder_flag_n, .tune_valid, .tune_take);

/* verification/sbd_ctrl_model.sv */
`timescale 1ns/1ns
module sbd_ctrl_model (
  // Clock, reset and step
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] step_index,
  // Remainder
  input wire logic remainder_flag_n,
  // Adjust requests
  output logic adj_up,
  output logic adj_down
);
  logic want;
  logic settle;
  logic moved;
  logic down;

  // Adjust on a remainder, but never on a flag that predates the last adjust
  assign want = rst_n & ~remainder_flag_n & ~settle;
  assign adj_up = want & ~down;
  assign adj_down = want & down;

  // One cycle of settling after each adjust; direction flips per search
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      settle <= 1'b0;
      moved <= 1'b0;
      down <= 1'b0;
    end else if (step_index == 5'h00) begin
      settle <= want;
      if (want) begin
        moved <= 1'b1;
      end else if (remainder_flag_n && moved && !settle) begin
        moved <= 1'b0;
        down <= ~down;
      end
    end
  end
endmodule

/* verification/tb_serial_bcd_frequency_band_divider.sv */
`timescale 1ns/1ns
module tb_serial_bcd_frequency_band_divider;
  import sbd_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, preset_req = 1'b0, tune_take = 1'b0;
  logic [3:0] band_number = 4'h1;
  logic [3:0] bnd = 4'h1;
  logic [31:0] xs = 32'h00000030;
  logic [4:0] step_index;
  logic adj_up, adj_down, shift_phase, remainder_flag_n, tune_valid, armed = 1'b0;
  logic freq_out_weight8, freq_out_weight4, freq_out_weight2, freq_out_weight1;
  logic [3:0] freq_return_digit;
  logic [4:0] loop_tune_m_field;
  logic [5:0] loop_tune_n_field;
  wire [3:0] fo = {freq_out_weight8, freq_out_weight4, freq_out_weight2, freq_out_weight1};
  logic [3:0] q[$];
  logic [3:0] qr[$];
  int mismatches = 0, check_count = 0, cyc = 0, val = 0, pw = 1, last = 0, n;
  sbd_divider_chain dut_u (.sys_clk, .rst_n, .preset_req, .adj_up, .adj_down, .band_number,
    .step_index, .shift_phase, .freq_out_weight8, .freq_out_weight4, .freq_out_weight2,
    .freq_out_weight1, .freq_return_digit, .divider_in_weight8(), .divider_in_weight4(),
    .divider_in_weight2(), .divider_in_weight1(), .data_path(), .remainder_flag_n,
    .tune_valid, .tune_take, .loop_tune_m_field, .loop_tune_n_field);
  sbd_ctrl_model ctl_u (.sys_clk, .rst_n, .step_index, .remainder_flag_n, .adj_up, .adj_down);
  always #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] nx(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(logic [3:0] got, logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_tune(logic [10:0] got, logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t tune got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wstep(logic [4:0] s);
    do @(negedge sys_clk); while (step_index !== s);
  endtask
  // Random pops and cycle ceiling
  always @(posedge sys_clk) begin
    xs <= nx(xs);
    tune_take <= xs[0];
    cyc++;
    if (cyc == 40000) begin
      $display("FAIL %0t cycle ceiling reached", $time);
      mismatches++;
      test_done();
    end
  end
  // Digit queue and remainder watch
  always @(negedge sys_clk) if (rst_n) begin
    if (step_index == 5'h00) begin
      if (armed) chk({3'h0, remainder_flag_n}, {3'h0, val % int'(bnd) == 0});
      last = val;
      armed = 1'b1;
      val = 0;
      pw = 1;
    end
    if (!shift_phase) begin
      val += pw * int'(fo);
      pw *= 10;
      if (q.size() != 0) chk(fo, q.pop_front());
    end
    // Adder result of digit k shows one step later
    if (step_index >= 5'h01 && step_index <= 5'h09 && qr.size() != 0) begin
      chk(freq_return_digit, qr.pop_front());
    end
    if (step_index == 5'h11) bnd = band_number;
  end
  // Preset, then retune to a random band
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk);
      band_number <= 4'h1;
      preset_req <= 1'b1;
      repeat (40) @(posedge sys_clk);
      preset_req <= 1'b0;
      wstep(5'h11);
      for (int k = 0; k < 9; k++) q.push_back(k == 6 ? 4'h3 : 4'h0);
      for (int k = 0; k < 9; k++) qr.push_back(k == 6 ? 4'h3 : 4'h0);
      @(posedge sys_clk);
      band_number <= 4'(xs[3:0] % 15 + 1);
      wstep(5'h00);
      n = 0;
      do begin
        wstep(5'h00);
        n++;
      end while (remainder_flag_n !== 1'b1 && n < 40);
      chk({3'h0, remainder_flag_n}, 4'h1);
      // Next pop carries the settled quotient of this band
      do @(posedge sys_clk); while (!(tune_valid && tune_take));
      @(negedge sys_clk);
      chk_tune({loop_tune_n_field, loop_tune_m_field}, 11'(3 * (last / 10000) - 811));
      $display("round %0d band %0d done after %0d cycles", r, band_number, n);
    end
    test_done();
  end
endmodule
